// ===== src/asf_pkg.sv
package asf_pkg;

   // ------------------------------------------------------------
   // Register location and field layout
   // ------------------------------------------------------------
   localparam logic [11:0] FLAG_REG_ADDR = 12'h0_FDB;
   localparam int          NEG_BIT       = 4;
   localparam int          OVF_BIT       = 3;
   localparam int          ZERO_BIT      = 2;
   localparam int          DCARRY_BIT    = 1;
   localparam int          CARRY_BIT     = 0;
   localparam logic [7:0]  IMPL_MASK     = 8'h1F;
   localparam logic [4:0]  FLAGS_RESET   = 5'h00;

   // ------------------------------------------------------------
   // Operations seen by the flag logic
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_NONE,
      OP_ADD_WORK_FILE,
      OP_ADD_LITERAL,
      OP_SUB_LITERAL,
      OP_SUB_WORK_FILE,
      OP_ROTATE_RIGHT,
      OP_ROTATE_LEFT,
      OP_LOGIC,
      OP_CLEAR_FILE,
      OP_NO_FLAGS
   } asf_op_t;

   // Operation request from the decoder
   typedef struct packed {
      logic       valid;
      asf_op_t    op;
      logic [7:0] opA;
      logic [7:0] opB;
   } asf_alu_req_t;

   // Data-memory write port
   typedef struct packed {
      logic        en;
      logic [11:0] addr;
      logic [7:0]  data;
   } asf_wr_t;

   // Result of one operation
   typedef struct packed {
      logic [7:0] result;
      logic [4:0] flags;
      logic [4:0] mask;
   } asf_alu_res_t;

endpackage

// ===== src/asf_status_flags.sv
`timescale 1ns/1ps
// What this block does
// (RQ1) The flag register reads and writes like any data-memory register.
// (RQ2) A flag-updating instruction aimed at the register gets ALU flags, not its write data.
// (RQ3) Clear-file on the register sets zero and leaves the other flags alone.
// (RQ4) Bit clear/set, nibble swap and both moves leave all five flags unaffected.
// (RQ5) Bits 7 to 5 ignore writes and read as zero.
// (RQ6) Negative follows the result MSB.
// (RQ7) Overflow is set when signed arithmetic flips the sign bit wrongly.
// (RQ8) Zero is set when an arithmetic or logic result is zero.
// (RQ9) Add/subtract set digit carry from the carry out of bit 3.
// (RQ10) Add/subtract set carry from the carry out of bit 7.
// (RQ11) Subtraction adds the two's complement, so carries mean no borrow.
// (RQ12) Rotates load digit carry from source bit 3 or 4.
// (RQ13) Rotates load carry from the bit shifted out.
// (RQ14) The register sits at access address FDBh.
// (RQ15) The flags have no defined value after reset.
module asf_status_flags (
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  reset_n,
   // Operation from decoder
   input  wire asf_pkg::asf_alu_req_t aluReq,
   input  wire logic                  carryIn,
   // Data-memory write and read
   input  wire asf_pkg::asf_wr_t      memWr,
   input  wire logic [11:0]           rdAddr,
   output logic [7:0]                 rdData,
   output logic                       rdHit,
   // ALU result and flag view
   output logic [7:0]                 aluResult,
   output logic [4:0]                 flags
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Address match, shared by read and write ports
   function automatic logic isFlagAddr(input logic [11:0] a);
      return a == asf_pkg::FLAG_REG_ADDR; // [RQ14]
   endfunction

   // Add with carry in, returning {dc, c, sum}
   function automatic logic [9:0] addc(input logic [7:0] a, input logic [7:0] b, input logic ci);
      logic [4:0] lo;
      logic [4:0] hi;
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
      return {lo[4], hi[4], hi[3:0], lo[3:0]};
   endfunction

   // Write strobe aimed at the flag register
   function automatic logic isFlagWrite(input asf_pkg::asf_wr_t w);
      return w.en && isFlagAddr(w.addr); // [RQ14]
   endfunction

   // ------------------------------------------------------------
   // Flag computation
   // ------------------------------------------------------------
   asf_pkg::asf_alu_res_t res;
   logic [9:0]            sum;
   logic [7:0]            addB;
   logic                  isSub;

   // Combinational ALU and per-operation flag mask
   always_comb begin
      isSub = (aluReq.op == asf_pkg::OP_SUB_LITERAL) || (aluReq.op == asf_pkg::OP_SUB_WORK_FILE);
      addB  = isSub ? ~aluReq.opB : aluReq.opB; // [RQ11]
      sum   = addc(aluReq.opA, addB, isSub); // [RQ11]
      res   = '0;
      case (aluReq.op)
         asf_pkg::OP_ADD_WORK_FILE, asf_pkg::OP_ADD_LITERAL,
         asf_pkg::OP_SUB_LITERAL, asf_pkg::OP_SUB_WORK_FILE: begin
            res.result                    = sum[7:0];
            res.flags[asf_pkg::NEG_BIT]   = sum[7]; // [RQ6]
            res.flags[asf_pkg::OVF_BIT]   = (aluReq.opA[7] == addB[7]) && (sum[7] != aluReq.opA[7]); // [RQ7]
            res.flags[asf_pkg::ZERO_BIT]  = sum[7:0] == 8'h00; // [RQ8]
            res.flags[asf_pkg::DCARRY_BIT] = sum[9]; // [RQ9]
            res.flags[asf_pkg::CARRY_BIT] = sum[8]; // [RQ10]
            res.mask                      = 5'h1F;
         end
         // Carry in is the decoder's copy of the carry flag
         asf_pkg::OP_ROTATE_RIGHT: begin
            res.result                    = {carryIn, aluReq.opA[7:1]};
            res.flags[asf_pkg::DCARRY_BIT] = aluReq.opA[4]; // [RQ12]
            res.flags[asf_pkg::CARRY_BIT] = aluReq.opA[0]; // [RQ13]
            res.flags[asf_pkg::NEG_BIT]   = carryIn;
            res.flags[asf_pkg::ZERO_BIT]  = {carryIn, aluReq.opA[7:1]} == 8'h00;
            res.mask                      = 5'h17;
         end
         asf_pkg::OP_ROTATE_LEFT: begin
            res.result                    = {aluReq.opA[6:0], carryIn};
            res.flags[asf_pkg::DCARRY_BIT] = aluReq.opA[3]; // [RQ12]
            res.flags[asf_pkg::CARRY_BIT] = aluReq.opA[7]; // [RQ13]
            res.flags[asf_pkg::NEG_BIT]   = aluReq.opA[6];
            res.flags[asf_pkg::ZERO_BIT]  = {aluReq.opA[6:0], carryIn} == 8'h00;
            res.mask                      = 5'h17;
         end
         // Only AND is built; other logic ops follow the same flag rules
         asf_pkg::OP_LOGIC: begin
            res.result                    = aluReq.opA & aluReq.opB;
            res.flags[asf_pkg::NEG_BIT]   = res.result[7]; // [RQ6]
            res.flags[asf_pkg::ZERO_BIT]  = res.result == 8'h00; // [RQ8]
            res.mask                      = 5'h14;
         end
         asf_pkg::OP_CLEAR_FILE: begin
            res.flags[asf_pkg::ZERO_BIT]  = 1'b1; // [RQ3]
            res.mask                      = 5'h04; // [RQ3]
         end
         asf_pkg::OP_NO_FLAGS: begin
            res.result                    = aluReq.opA;
            res.mask                      = 5'h00; // [RQ4]
         end
         default: begin
            res = '0;
         end
      endcase
      if (!aluReq.valid) begin
         res.mask = 5'h00;
      end
   end

   // ------------------------------------------------------------
   // Flag register
   // ------------------------------------------------------------
   logic [4:0] flagReg;
   logic [4:0] next_flagReg;
   logic [4:0] wrMask;

   // ALU flags override the bus write on flag bits they own.
   // Any flag-updating op locks all five flags against the bus write, so a
   // clear aimed here keeps N, OV, DC and C instead of zeroing them.
   always_comb begin
      wrMask       = (isFlagWrite(memWr) && res.mask == 5'h00) ? 5'h1F : 5'h00; // [RQ2] [RQ3] [RQ1]
      next_flagReg = (flagReg & ~wrMask & ~res.mask)
                   | (memWr.data[4:0] & wrMask) // [RQ5]
                   | (res.flags & res.mask); // [RQ2]
   end

   // Reset value is arbitrary to software; zero keeps simulation clean
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         flagReg <= asf_pkg::FLAGS_RESET; // [RQ15]
      end else begin
         flagReg <= next_flagReg;
      end
   end

   // ------------------------------------------------------------
   // Read port and result
   // ------------------------------------------------------------
   // Unimplemented top bits forced low on the way out
   assign rdHit     = isFlagAddr(rdAddr);
   assign rdData    = rdHit ? ({3'b000, flagReg} & asf_pkg::IMPL_MASK) : 8'h00; // [RQ5] [RQ1]
   assign aluResult = res.result;
   assign flags     = flagReg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   sequence s_clrFlag;
      aluReq.valid && aluReq.op == asf_pkg::OP_CLEAR_FILE;
   endsequence

   a_clear_sets_zero: assert property (s_clrFlag |=> flags[asf_pkg::ZERO_BIT] // [RQ3]
      && flags[1:0] == $past(flags[1:0]) && flags[4:3] == $past(flags[4:3]))
      else $error("clear did not set zero only");
   a_no_flag_ops: assert property (aluReq.valid && aluReq.op == asf_pkg::OP_NO_FLAGS // [RQ4]
      && !(memWr.en && isFlagAddr(memWr.addr)) |=> flags == $past(flags))
      else $error("flag changed on flag-neutral op");
   a_upper_zero: assert property (rdData[7:5] == 3'b000) // [RQ5]
      else $error("upper bits not zero");
   a_write_blocked: assert property (memWr.en && isFlagAddr(memWr.addr) && aluReq.valid // [RQ2]
      && aluReq.op == asf_pkg::OP_ADD_LITERAL |=> flags == $past(res.flags))
      else $error("write overrode alu flags");
   a_plain_write: assert property (memWr.en && isFlagAddr(memWr.addr) && !aluReq.valid // [RQ1]
      |=> flags == $past(memWr.data[4:0]))
      else $error("plain write lost");
   a_sub_borrow: assert property (aluReq.valid && aluReq.op == asf_pkg::OP_SUB_LITERAL // [RQ11]
      |=> flags[asf_pkg::CARRY_BIT] == ($past(aluReq.opA) >= $past(aluReq.opB)))
      else $error("borrow polarity wrong");
   a_add_zero: assert property (aluReq.valid && aluReq.op == asf_pkg::OP_ADD_LITERAL // [RQ8]
      |=> flags[asf_pkg::ZERO_BIT] == (8'($past(aluReq.opA) + $past(aluReq.opB)) == 8'h00))
      else $error("zero flag wrong");
   a_rot_carry: assert property (aluReq.valid && aluReq.op == asf_pkg::OP_ROTATE_LEFT // [RQ13]
      |=> flags[asf_pkg::CARRY_BIT] == $past(aluReq.opA[7]) && flags[1] == $past(aluReq.opA[3]))
      else $error("rotate carry wrong");

   // ------------------------------------------------------------
   // Checks: arithmetic and rotate flags
   // ------------------------------------------------------------
   // Request classes shared by the properties below
   sequence s_addOp;
      aluReq.valid && (aluReq.op == asf_pkg::OP_ADD_WORK_FILE || aluReq.op == asf_pkg::OP_ADD_LITERAL);
   endsequence

   sequence s_subOp;
      aluReq.valid && (aluReq.op == asf_pkg::OP_SUB_LITERAL || aluReq.op == asf_pkg::OP_SUB_WORK_FILE);
   endsequence

   sequence s_rotRight;
      aluReq.valid && aluReq.op == asf_pkg::OP_ROTATE_RIGHT;
   endsequence

   // Carry and digit carry from operand widths, not from the adder
   a_add_carry: assert property (s_addOp // [RQ10]
      |=> flags[asf_pkg::CARRY_BIT] == ((9'($past(aluReq.opA)) + 9'($past(aluReq.opB))) > 9'h0FF))
      else $error("add carry wrong");
   a_add_digit: assert property (s_addOp // [RQ9]
      |=> flags[asf_pkg::DCARRY_BIT] == ((5'($past(aluReq.opA[3:0])) + 5'($past(aluReq.opB[3:0]))) > 5'h0F))
      else $error("add digit carry wrong");
   a_add_file_zero: assert property (s_addOp // [RQ8]
      |=> flags[asf_pkg::ZERO_BIT] == (8'($past(aluReq.opA) + $past(aluReq.opB)) == 8'h00))
      else $error("add zero wrong");

   // A set carry means no borrow, on both subtract forms
   a_sub_carry: assert property (s_subOp // [RQ11]
      |=> flags[asf_pkg::CARRY_BIT] == ($past(aluReq.opA) >= $past(aluReq.opB)))
      else $error("subtract borrow wrong");
   a_sub_digit: assert property (s_subOp // [RQ11]
      |=> flags[asf_pkg::DCARRY_BIT] == ($past(aluReq.opA[3:0]) >= $past(aluReq.opB[3:0])))
      else $error("subtract digit borrow wrong");
   a_sub_result: assert property (s_subOp // [RQ11]
      |-> aluResult == 8'(aluReq.opA - aluReq.opB))
      else $error("subtract result wrong");
   a_sub_zero: assert property (s_subOp // [RQ8]
      |=> flags[asf_pkg::ZERO_BIT] == ($past(aluReq.opA) == $past(aluReq.opB)))
      else $error("subtract zero wrong");

   // Sign and signed overflow from the operand signs
   a_add_negative: assert property (s_addOp // [RQ6]
      |=> flags[asf_pkg::NEG_BIT] == (8'($past(aluReq.opA) + $past(aluReq.opB)) >= 8'h80))
      else $error("add negative wrong");
   a_sub_negative: assert property (s_subOp // [RQ6]
      |=> flags[asf_pkg::NEG_BIT] == (8'($past(aluReq.opA) - $past(aluReq.opB)) >= 8'h80))
      else $error("subtract negative wrong");
   a_add_overflow: assert property (s_addOp // [RQ7]
      |=> flags[asf_pkg::OVF_BIT] == ($past(aluReq.opA[7]) == $past(aluReq.opB[7])
      && $past(aluResult[7]) != $past(aluReq.opA[7])))
      else $error("add overflow wrong");
   a_sub_overflow: assert property (s_subOp // [RQ7]
      |=> flags[asf_pkg::OVF_BIT] == ($past(aluReq.opA[7]) != $past(aluReq.opB[7])
      && $past(aluResult[7]) != $past(aluReq.opA[7])))
      else $error("subtract overflow wrong");

   // Right rotate: carry takes bit 0, digit carry bit 4
   a_rot_right: assert property (s_rotRight // [RQ12] [RQ13]
      |=> flags[asf_pkg::CARRY_BIT] == $past(aluReq.opA[0])
      && flags[asf_pkg::DCARRY_BIT] == $past(aluReq.opA[4]))
      else $error("right rotate flags wrong");

   // ------------------------------------------------------------
   // Checks: register port and flag-neutral traffic
   // ------------------------------------------------------------
   // Request classes for logic, flag-neutral, idle and plain-write traffic
   sequence s_logicOp;
      aluReq.valid && aluReq.op == asf_pkg::OP_LOGIC;
   endsequence

   sequence s_neutralWrite;
      aluReq.valid && aluReq.op == asf_pkg::OP_NO_FLAGS && isFlagWrite(memWr);
   endsequence

   sequence s_idle;
      !aluReq.valid && !isFlagWrite(memWr);
   endsequence

   sequence s_plainWrite;
      !aluReq.valid && isFlagWrite(memWr);
   endsequence

   // Logic ops own N and Z only; OV, DC and C stay even under a bus write
   a_logic_flags: assert property (s_logicOp // [RQ2] [RQ8]
      |=> flags[asf_pkg::ZERO_BIT] == ($past(aluReq.opA & aluReq.opB) == 8'h00)
      && flags[asf_pkg::OVF_BIT] == $past(flags[asf_pkg::OVF_BIT]) && flags[1:0] == $past(flags[1:0]))
      else $error("logic op flags wrong");
   a_logic_negative: assert property (s_logicOp // [RQ6]
      |=> flags[asf_pkg::NEG_BIT] == ($past(aluReq.opA[7]) && $past(aluReq.opB[7])))
      else $error("logic negative wrong");
   a_clear_result: assert property (s_clrFlag // [RQ3]
      |-> aluResult == 8'h00)
      else $error("clear result not zero");

   // Moves and the like: the bus write lands whole on the five flags
   a_neutral_write: assert property (s_neutralWrite // [RQ4] [RQ1]
      |=> flags == $past(memWr.data[4:0]))
      else $error("neutral write lost");

   // Nothing aimed at the register, so the flags must hold
   a_idle_hold: assert property (s_idle // [RQ1]
      |=> $stable(flags))
      else $error("flags changed while idle");

   // Read view tracks the register while addressed
   a_read_view: assert property (rdHit // [RQ1] [RQ5]
      |-> rdData == {3'b000, flags})
      else $error("read view differs from flags");
   a_addr_decode: assert property (rdHit == (rdAddr == asf_pkg::FLAG_REG_ADDR)) // [RQ14]
      else $error("address decode wrong");
   // Plain write reads back a cycle later, top bits dropped
   a_write_readback: assert property (s_plainWrite ##1 rdHit // [RQ1] [RQ5]
      |-> rdData == {3'b000, $past(memWr.data[4:0])})
      else $error("write did not read back");

endmodule

// ===== tb/asf_core_model.sv
`timescale 1ns/1ps
// Decoder side: one request a cycle, launched off the sampling edge
module asf_core_model (
   // Clock
   input  wire logic             core_clk,
   // Requests toward the flag block
   output asf_pkg::asf_alu_req_t aluReq,
   output asf_pkg::asf_wr_t      memWr,
   output logic                  carryIn
);
   // Idle until the first request
   initial begin
      aluReq  = '0;
      memWr   = '0;
      carryIn = 1'b0;
   end
   // Held through the next rising edge, so setup never races it
   task automatic issue(input asf_pkg::asf_op_t op, input logic [7:0] a, b, input logic we,
                        input logic [7:0] wd, input logic ci);
      @(negedge core_clk);
      aluReq  = '{op != asf_pkg::OP_NONE, op, a, b};
      memWr   = '{we, asf_pkg::FLAG_REG_ADDR, wd};
      carryIn = ci;
   endtask
endmodule

// ===== tb/alu_status_flags_tb_top.sv
`timescale 1ns/1ps
module alu_status_flags_tb_top;
   logic                  core_clk, reset_n, carryIn, rdHit;
   asf_pkg::asf_alu_req_t aluReq;
   asf_pkg::asf_wr_t      memWr;
   logic [11:0]           rdAddr;
   logic [7:0]            rdData, aluResult;
   logic [4:0]            flags, mFlags;
   int                    mismatches, comparisons, cycles;

   asf_core_model i_core (.core_clk(core_clk), .aluReq(aluReq), .memWr(memWr), .carryIn(carryIn));
   asf_status_flags i_dut (.core_clk(core_clk), .reset_n(reset_n), .aluReq(aluReq), .carryIn(carryIn),
      .memWr(memWr), .rdAddr(rdAddr), .rdData(rdData), .rdHit(rdHit), .aluResult(aluResult), .flags(flags));

   // ------------------------------------------------------------
   // Clock, timeout and checking
   // ------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // Bound far above the ~135 cycles the tests need
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         final_report();
      end
   end
   task automatic chk(input logic [12:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Reference model: {result, flags}
   // ------------------------------------------------------------
   function automatic logic [12:0] model(asf_pkg::asf_op_t op, logic [7:0] a, b, logic [4:0] old);
      int         bb, s, sub;
      logic [7:0] r;
      sub = (op == asf_pkg::OP_SUB_LITERAL || op == asf_pkg::OP_SUB_WORK_FILE);
      bb  = sub ? 255 - b : b;
      s   = a + bb + sub;
      r   = 8'(s);
      if (op == asf_pkg::OP_LOGIC) begin
         r = a & b;
         return {r, r[7], old[3], r == 8'h00, old[1:0]};
      end
      if (op == asf_pkg::OP_CLEAR_FILE) return {8'h00, old | 5'h04};
      return {r, r[7], (a[7] == bb[7]) && (r[7] != a[7]), r == 8'h00, ((a % 16) + (bb % 16) + sub) > 15, s > 255};
   endfunction
   // One operation, optionally with a bus write aimed at the flag register
   task automatic run(input asf_pkg::asf_op_t op, input logic [7:0] a, b, input logic we, input logic [7:0] wd);
      logic [12:0] m;
      logic        upd;
      m   = model(op, a, b, mFlags);
      upd = op != asf_pkg::OP_NONE && op != asf_pkg::OP_NO_FLAGS;
      i_core.issue(op, a, b, we, wd, 1'b0);
      #5;
      chk({4'h0, rdHit, rdData}, {5'h01, 3'h0, mFlags});
      if (upd) chk({5'h00, aluResult}, {5'h00, m[12:5]});
      @(posedge core_clk);
      #1;
      mFlags = upd ? m[4:0] : (we ? wd[4:0] : mFlags);
      chk({8'h00, flags}, {8'h00, mFlags});
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      rdAddr  = asf_pkg::FLAG_REG_ADDR;
      void'($urandom(84056));
      repeat (16) @(posedge core_clk);
      @(negedge core_clk) reset_n = 1'b1;
      // No reset value assumed: a bus write sets a known state
      mFlags = 5'h1F;
      i_core.issue(asf_pkg::OP_NONE, 8'h00, 8'h00, 1'b1, 8'hFF, 1'b0);
      @(negedge core_clk) rdAddr = 12'h0_FDA;
      #5 chk({4'h0, rdHit, rdData}, 13'h0000);
      rdAddr = asf_pkg::FLAG_REG_ADDR;
      $display("Test seed and decode done");
      // Boundaries, then random add/subtract with clashing bus writes
      run(asf_pkg::OP_ADD_LITERAL, 8'h0F, 8'h01, 1'b0, 8'h00);
      run(asf_pkg::OP_ADD_WORK_FILE, 8'h7F, 8'h01, 1'b1, 8'h00);
      run(asf_pkg::OP_SUB_LITERAL, 8'h00, 8'h01, 1'b0, 8'h00);
      run(asf_pkg::OP_SUB_WORK_FILE, 8'h80, 8'h01, 1'b1, 8'hFF);
      for (int i = 0; i < 64; i++) begin
         run(asf_pkg::asf_op_t'(1 + $urandom_range(3)), 8'($urandom), 8'($urandom), 1'($urandom), 8'($urandom));
      end
      $display("Test arithmetic done");
      // Logic, clear and flag-neutral writes to the register
      for (int i = 0; i < 8; i++) begin
         run(asf_pkg::OP_LOGIC, 8'($urandom), 8'($urandom), 1'b1, 8'($urandom));
         run(asf_pkg::OP_CLEAR_FILE, 8'h00, 8'h00, 1'b1, 8'h00);
         run(asf_pkg::OP_NO_FLAGS, 8'h00, 8'h00, 1'b1, 8'($urandom));
         run(asf_pkg::OP_NONE, 8'h00, 8'h00, 1'b0, 8'h00);
      end
      $display("Test logic clear neutral done");
      // Rotates: carry takes the bit shifted out
      for (int i = 0; i < 8; i++) begin
         i_core.issue(asf_pkg::OP_ROTATE_RIGHT, 8'(1 << i), 8'h00, 1'b0, 8'h00, 1'b0);
         @(posedge core_clk) #1 chk({11'h000, flags[1:0]}, {11'h000, i == 4, i == 0});
         i_core.issue(asf_pkg::OP_ROTATE_LEFT, 8'(1 << i), 8'h00, 1'b0, 8'h00, 1'b1);
         @(posedge core_clk) #1 chk({11'h000, flags[1:0]}, {11'h000, i == 3, i == 7});
      end
      $display("Test rotate done");
      final_report();
   end
endmodule
